/* File: rtl/eag_pkg.sv */
package eag_pkg;

  // Addressing modes, one-hot
  typedef enum logic [10:0] {
    MODE_ACCUM     = 11'h001,
    MODE_IMMED     = 11'h002,
    MODE_ABS       = 11'h004,
    MODE_ZPAGE     = 11'h008,
    MODE_ZPAGE_IDX = 11'h010,
    MODE_ABS_IDX   = 11'h020,
    MODE_IMPLIED   = 11'h040,
    MODE_RELATIVE  = 11'h080,
    MODE_IND_X     = 11'h100,
    MODE_IND_Y     = 11'h200,
    MODE_ABS_IND   = 11'h400
  } addr_mode_e;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PTR_LO = 4'h2,
    ST_PTR_HI = 4'h4,
    ST_DONE = 4'h8
  } seq_state_e;

  localparam logic [7:0] ZERO_PAGE_HI = 8'h00;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int SIGN_BIT = 7;

endpackage : eag_pkg

/* File: rtl/ea_adder.sv */
`timescale 1ns/1ns
// Index/offset adder: 16-bit base plus 8-bit addend, optional sign
// extension, optional wrap within the base page.
module offset_adder (
  input wire logic [15:0] base,
  input wire logic [7:0] addend,
  input wire logic sign_extend,
  input wire logic page_wrap,
  output logic [15:0] sum
);

  wire logic [7:0] ext_hi;
  wire logic [15:0] full_sum;
  wire logic [7:0] low_sum;

  assign ext_hi = (sign_extend && addend[eag_pkg::SIGN_BIT]) ? 8'hff : 8'h00;
  assign full_sum = base + {ext_hi, addend};
  assign low_sum = base[7:0] + addend;
  assign sum = page_wrap ? {base[15:8], low_sum} : full_sum;

endmodule : offset_adder

/* File: rtl/effective_address_generator.sv */
`timescale 1ns/1ns
module effective_address_generator (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [10:0] mode,
  input wire logic index_sel_y,
  input wire logic [7:0] operand_lo,
  input wire logic [7:0] operand_hi,
  input wire logic [7:0] index_x,
  input wire logic [7:0] index_y,
  input wire logic [15:0] pc_next,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  output logic mem_req,
  output logic [15:0] mem_addr,
  output logic done,
  output logic [15:0] eff_addr,
  output logic addr_valid,
  output logic use_accum,
  output logic use_immediate,
  output logic [7:0] imm_data,
  output logic load_pc,
  output logic [2:0] operand_bytes
);

  eag_pkg::seq_state_e state;
  eag_pkg::seq_state_e next_state;
  eag_pkg::addr_mode_e cur_mode;
  logic [7:0] cur_lo;
  logic [7:0] cur_hi;
  logic [7:0] cur_x;
  logic [7:0] cur_y;
  logic [15:0] cur_pc;
  logic cur_sel_y;
  logic [7:0] ptr_lo_data;

  wire logic is_indirect;
  wire logic [7:0] index_val;
  wire logic [15:0] abs_base;
  wire logic [15:0] zp_base;
  wire logic [15:0] idx_sum;
  wire logic [15:0] rel_sum;
  wire logic [15:0] indx_ptr;
  wire logic [15:0] ptr_first;
  wire logic [15:0] ptr_second;
  wire logic [15:0] indy_sum;
  wire logic [15:0] direct_addr;
  wire logic [15:0] indirect_addr;
  wire logic [2:0] bytes_for_mode;

  function automatic logic [2:0] mode_bytes(input logic [10:0] m);
    logic [2:0] n;
    n = 3'h2;
    if (m == eag_pkg::MODE_ACCUM || m == eag_pkg::MODE_IMPLIED) begin
      n = 3'h1;
    end else if (m == eag_pkg::MODE_ABS || m == eag_pkg::MODE_ABS_IDX ||
                 m == eag_pkg::MODE_ABS_IND) begin
      n = 3'h3;
    end
    return n;
  endfunction : mode_bytes

  assign is_indirect = (cur_mode == eag_pkg::MODE_IND_X) ||
                       (cur_mode == eag_pkg::MODE_IND_Y) ||
                       (cur_mode == eag_pkg::MODE_ABS_IND);
  assign index_val = cur_sel_y ? cur_y : cur_x;
  assign abs_base = {cur_hi, cur_lo};
  assign zp_base = {eag_pkg::ZERO_PAGE_HI, cur_lo};
  assign bytes_for_mode = mode_bytes(mode);

  // Indexed forms: zero page wraps, absolute carries
  offset_adder u_idx (
    .base(cur_mode == eag_pkg::MODE_ZPAGE_IDX ? zp_base : abs_base),
    .addend(index_val),
    .sign_extend(1'b0),
    .page_wrap(cur_mode == eag_pkg::MODE_ZPAGE_IDX),
    .sum(idx_sum)
  );

  offset_adder u_rel (
    .base(cur_pc),
    .addend(cur_lo),
    .sign_extend(1'b1),
    .page_wrap(1'b0),
    .sum(rel_sum)
  );

  offset_adder u_indx (
    .base(zp_base),
    .addend(cur_x),
    .sign_extend(1'b0),
    .page_wrap(1'b1),
    .sum(indx_ptr)
  );

  // Pointer location for the first pointer byte
  assign ptr_first = (cur_mode == eag_pkg::MODE_IND_X) ? indx_ptr :
                     (cur_mode == eag_pkg::MODE_IND_Y) ? zp_base :
                     abs_base;

  // Second pointer byte: page-zero pointers wrap, absolute carries
  offset_adder u_ptr2 (
    .base(ptr_first),
    .addend(8'h01),
    .sign_extend(1'b0),
    .page_wrap(cur_mode != eag_pkg::MODE_ABS_IND),
    .sum(ptr_second)
  );

  // Pointer low plus Y, carry into the high pointer byte
  offset_adder u_indy (
    .base({mem_rdata, ptr_lo_data}),
    .addend(cur_y),
    .sign_extend(1'b0),
    .page_wrap(1'b0),
    .sum(indy_sum)
  );

  assign direct_addr =
    (cur_mode == eag_pkg::MODE_ABS) ? abs_base :
    (cur_mode == eag_pkg::MODE_ZPAGE) ? zp_base :
    (cur_mode == eag_pkg::MODE_RELATIVE) ? rel_sum :
    idx_sum;
  assign indirect_addr = (cur_mode == eag_pkg::MODE_IND_Y) ? indy_sum :
                         {mem_rdata, ptr_lo_data};

  always_comb begin
    next_state = state;
    case (state)
      eag_pkg::ST_IDLE: begin
        if (start) begin
          next_state = eag_pkg::ST_DONE;
        end
      end
      eag_pkg::ST_PTR_LO: begin
        if (mem_ack) begin
          next_state = eag_pkg::ST_PTR_HI;
        end
      end
      eag_pkg::ST_PTR_HI: begin
        if (mem_ack) begin
          next_state = eag_pkg::ST_IDLE;
        end
      end
      eag_pkg::ST_DONE: begin
        next_state = is_indirect ? eag_pkg::ST_PTR_LO : eag_pkg::ST_IDLE;
      end
      default: begin
        next_state = eag_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= eag_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Capture request fields so a changing sequencer does not disturb us
  always_ff @(posedge clk) begin
    if (reset) begin
      cur_mode <= eag_pkg::MODE_IMPLIED;
      cur_lo <= eag_pkg::BYTE_RESET;
      cur_hi <= eag_pkg::BYTE_RESET;
      cur_x <= eag_pkg::BYTE_RESET;
      cur_y <= eag_pkg::BYTE_RESET;
      cur_pc <= eag_pkg::ADDR_RESET;
      cur_sel_y <= 1'b0;
    end else if (state == eag_pkg::ST_IDLE && start) begin
      cur_mode <= eag_pkg::addr_mode_e'(mode);
      cur_lo <= operand_lo;
      cur_hi <= operand_hi;
      cur_x <= index_x;
      cur_y <= index_y;
      cur_pc <= pc_next;
      cur_sel_y <= index_sel_y;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ptr_lo_data <= eag_pkg::BYTE_RESET;
    end else if (state == eag_pkg::ST_PTR_LO && mem_ack) begin
      ptr_lo_data <= mem_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      operand_bytes <= 3'h0;
    end else if (state == eag_pkg::ST_IDLE && start) begin
      operand_bytes <= bytes_for_mode;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mem_req <= 1'b0;
      mem_addr <= eag_pkg::ADDR_RESET;
    end else if (state == eag_pkg::ST_DONE && is_indirect) begin
      mem_req <= 1'b1;
      mem_addr <= ptr_first;
    end else if (state == eag_pkg::ST_PTR_LO && mem_ack) begin
      mem_req <= 1'b1;
      mem_addr <= ptr_second;
    end else if (state == eag_pkg::ST_PTR_HI && mem_ack) begin
      mem_req <= 1'b0;
    end
  end

  // Result outputs: one-cycle done pulse, result held until next start
  always_ff @(posedge clk) begin
    if (reset) begin
      done <= 1'b0;
      eff_addr <= eag_pkg::ADDR_RESET;
      addr_valid <= 1'b0;
      use_accum <= 1'b0;
      use_immediate <= 1'b0;
      imm_data <= eag_pkg::BYTE_RESET;
      load_pc <= 1'b0;
    end else begin
      done <= 1'b0;
      if (state == eag_pkg::ST_DONE && !is_indirect) begin
        done <= 1'b1;
        use_accum <= (cur_mode == eag_pkg::MODE_ACCUM);
        use_immediate <= (cur_mode == eag_pkg::MODE_IMMED);
        imm_data <= cur_lo;
        addr_valid <= (cur_mode != eag_pkg::MODE_ACCUM) &&
                      (cur_mode != eag_pkg::MODE_IMMED) &&
                      (cur_mode != eag_pkg::MODE_IMPLIED);
        eff_addr <= direct_addr;
        load_pc <= (cur_mode == eag_pkg::MODE_RELATIVE);
      end else if (state == eag_pkg::ST_PTR_HI && mem_ack) begin
        done <= 1'b1;
        use_accum <= 1'b0;
        use_immediate <= 1'b0;
        addr_valid <= 1'b1;
        eff_addr <= indirect_addr;
        load_pc <= (cur_mode == eag_pkg::MODE_ABS_IND);
      end else if (state == eag_pkg::ST_IDLE && start) begin
        addr_valid <= 1'b0;
        load_pc <= 1'b0;
      end
    end
  end

  sequence s_ptr_lo_ack;
    state == eag_pkg::ST_PTR_LO && mem_ack;
  endsequence

  sequence s_ptr_hi_ack;
    state == eag_pkg::ST_PTR_HI && mem_ack;
  endsequence

  a_zp_wrap: assert property (@(posedge clk) disable iff (reset)
    done && cur_mode == eag_pkg::MODE_ZPAGE_IDX |->
    eff_addr == {8'h00, 8'(cur_lo + index_val)})
    else $error("zero page index left page zero");

  a_abs_carry: assert property (@(posedge clk) disable iff (reset)
    done && cur_mode == eag_pkg::MODE_ABS_IDX |->
    eff_addr == 16'({cur_hi, cur_lo} + {8'h00, index_val}))
    else $error("absolute index wrong");

  a_zp_direct: assert property (@(posedge clk) disable iff (reset)
    done && cur_mode == eag_pkg::MODE_ZPAGE |-> eff_addr == {8'h00, cur_lo})
    else $error("zero page high not zero");

  a_abs_direct: assert property (@(posedge clk) disable iff (reset)
    done && cur_mode == eag_pkg::MODE_ABS |-> eff_addr == {cur_hi, cur_lo})
    else $error("absolute byte order wrong");

  a_rel_target: assert property (
    @(posedge clk) disable iff (reset)
    done && cur_mode == eag_pkg::MODE_RELATIVE |->
    eff_addr == 16'(cur_pc + {{8{cur_lo[7]}}, cur_lo}) && load_pc)
    else $error("branch target wrong");

  a_no_fetch: assert property (
    @(posedge clk) disable iff (reset)
    state == eag_pkg::ST_DONE && !is_indirect |=> !mem_req && done)
    else $error("fetch in a non-indirect mode");

  a_accum_flag: assert property (@(posedge clk) disable iff (reset)
    done && cur_mode == eag_pkg::MODE_ACCUM |-> use_accum && !addr_valid)
    else $error("accumulator mode gave an address");

  a_immed_data: assert property (@(posedge clk) disable iff (reset)
    done && cur_mode == eag_pkg::MODE_IMMED |->
    use_immediate && imm_data == cur_lo && !addr_valid)
    else $error("immediate operand wrong");

  a_indx_wrap: assert property (
    @(posedge clk) disable iff (reset)
    state == eag_pkg::ST_PTR_HI && cur_mode == eag_pkg::MODE_IND_X |->
    mem_addr[15:8] == 8'h00)
    else $error("indirect X pointer left page zero");

  a_ptr_next: assert property (
    @(posedge clk) disable iff (reset)
    s_ptr_lo_ack |=>
    mem_req && mem_addr[7:0] == 8'($past(mem_addr[7:0]) + 8'h01))
    else $error("second pointer byte address wrong");

  a_indy_result: assert property (
    @(posedge clk) disable iff (reset)
    s_ptr_hi_ack ##0 cur_mode == eag_pkg::MODE_IND_Y |=>
    done && addr_valid &&
    eff_addr == 16'({$past(mem_rdata), ptr_lo_data} + {8'h00, cur_y}))
    else $error("indirect Y result wrong");

  a_ind_load: assert property (
    @(posedge clk) disable iff (reset)
    s_ptr_hi_ack |=> done && addr_valid &&
    load_pc == (cur_mode == eag_pkg::MODE_ABS_IND))
    else $error("indirect program counter load wrong");

endmodule : effective_address_generator

/* File: verif/mem_model.sv */
`timescale 1ns/1ns
// Pointer memory: answers each read after lat idle cycles; the data
// bus shows the inverse of its last value whenever it is not answering
module mem_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  logic [3:0] cnt;
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h5a;
  endfunction : pat
  always_ff @(posedge clk) begin
    if (reset) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= 8'h00;
    end else if (mem_req && !mem_ack && cnt >= lat) begin
      mem_ack <= 1'b1;
      mem_rdata <= pat(mem_addr);
      cnt <= 4'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : mem_model

/* File: verif/tb.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch %0t %h %h", $time, (a), (e)); end end
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic [10:0] mode = 11'h001;
  logic index_sel_y = 1'b0;
  logic [7:0] operand_lo = 8'h00, operand_hi = 8'h00;
  logic [7:0] index_x = 8'h00, index_y = 8'h00;
  logic [15:0] pc_next = 16'h0000;
  logic [3:0] lat = 4'h0;
  logic mem_ack, mem_req, done, addr_valid, use_accum, use_immediate;
  logic load_pc;
  logic [7:0] mem_rdata, imm_data;
  logic [15:0] mem_addr, eff_addr;
  logic [2:0] operand_bytes;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  effective_address_generator dut (.clk(clk), .reset(reset),
    .start(start), .mode(mode), .index_sel_y(index_sel_y),
    .operand_lo(operand_lo), .operand_hi(operand_hi),
    .index_x(index_x), .index_y(index_y), .pc_next(pc_next),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_req(mem_req),
    .mem_addr(mem_addr), .done(done), .eff_addr(eff_addr),
    .addr_valid(addr_valid), .use_accum(use_accum),
    .use_immediate(use_immediate), .imm_data(imm_data),
    .load_pc(load_pc), .operand_bytes(operand_bytes));
  mem_model pm (.clk(clk), .reset(reset), .mem_req(mem_req),
    .mem_addr(mem_addr), .lat(lat), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  always #50 clk = ~clk;
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h5a;
  endfunction : pat
  task close_out;
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      close_out();
    end
  end
  // One request, held for the taking edge, then wait for done
  task go(input logic [10:0] m, input logic s, input logic [7:0] lo, hi);
    int i;
    @(posedge clk);
    start <= 1'b1;
    mode <= m;
    index_sel_y <= s;
    operand_lo <= lo;
    operand_hi <= hi;
    @(posedge clk);
    start <= 1'b0;
    i = 0;
    while (done !== 1'b1 && i < 40) begin
      @(posedge clk);
      i++;
    end
    `CHK(done, 1'b1)
  endtask : go
  task t_accum;
    go(eag_pkg::MODE_ACCUM, 1'b0, 8'h12, 8'h34);
    `CHK(use_accum, 1'b1)
    `CHK(addr_valid, 1'b0)
    `CHK(operand_bytes, 3'h1)
    `CHK(use_immediate, 1'b0)
  endtask : t_accum
  task t_immed;
    go(eag_pkg::MODE_IMMED, 1'b0, 8'ha5, 8'h34);
    `CHK(use_immediate, 1'b1)
    `CHK(imm_data, 8'ha5)
    `CHK(use_accum, 1'b0)
    `CHK(addr_valid, 1'b0)
    `CHK(operand_bytes, 3'h2)
  endtask : t_immed
  task t_direct;
    go(eag_pkg::MODE_ABS, 1'b0, 8'h34, 8'h12);
    `CHK(eff_addr, 16'h1234)
    `CHK(operand_bytes, 3'h3)
    `CHK(addr_valid, 1'b1)
    `CHK(load_pc, 1'b0)
    go(eag_pkg::MODE_ZPAGE, 1'b0, 8'h9c, 8'h77);
    `CHK(eff_addr, 16'h009c)
    `CHK(operand_bytes, 3'h2)
    `CHK(addr_valid, 1'b1)
    go(eag_pkg::MODE_IMPLIED, 1'b0, 8'h9c, 8'h77);
    `CHK(addr_valid, 1'b0)
    `CHK(operand_bytes, 3'h1)
  endtask : t_direct
  task t_indexed;
    index_x <= 8'h20;
    index_y <= 8'h70;
    go(eag_pkg::MODE_ZPAGE_IDX, 1'b0, 8'hf0, 8'h55);
    `CHK(eff_addr, 16'h0010)
    go(eag_pkg::MODE_ZPAGE_IDX, 1'b1, 8'hf0, 8'h55);
    `CHK(eff_addr, 16'h0060)
    go(eag_pkg::MODE_ABS_IDX, 1'b0, 8'hf0, 8'h12);
    `CHK(eff_addr, 16'h1310)
    go(eag_pkg::MODE_ABS_IDX, 1'b1, 8'hf0, 8'hff);
    `CHK(eff_addr, 16'h0060)
  endtask : t_indexed
  task t_rel;
    pc_next <= 16'h1280;
    go(eag_pkg::MODE_RELATIVE, 1'b0, 8'h80, 8'h00);
    `CHK(eff_addr, 16'h1200)
    `CHK(load_pc, 1'b1)
    go(eag_pkg::MODE_RELATIVE, 1'b0, 8'h7f, 8'h00);
    `CHK(eff_addr, 16'h12ff)
  endtask : t_rel
  task t_indirect;
    index_x <= 8'h0f;
    index_y <= 8'hff;
    go(eag_pkg::MODE_IND_X, 1'b0, 8'hf0, 8'h00);
    `CHK(eff_addr, {pat(16'h0000), pat(16'h00ff)})
    `CHK(addr_valid, 1'b1)
    `CHK(load_pc, 1'b0)
    lat <= 4'h3;
    go(eag_pkg::MODE_IND_Y, 1'b0, 8'h40, 8'h00);
    `CHK(eff_addr, {pat(16'h0041), pat(16'h0040)} + 16'h00ff)
    `CHK(addr_valid, 1'b1)
    lat <= 4'h1;
    go(eag_pkg::MODE_ABS_IND, 1'b0, 8'hff, 8'h12);
    `CHK(eff_addr, {pat(16'h1300), pat(16'h12ff)})
    `CHK(load_pc, 1'b1)
    `CHK(mem_req, 1'b0)
  endtask : t_indirect
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_accum();
    t_immed();
    t_direct();
    t_indexed();
    t_rel();
    t_indirect();
    close_out();
  end
endmodule : tb
